// ---- shared/pmao_pkg.sv ----
// Purpose: shared types and constants of the privileged/arith execute slice
// Assumes: 32-bit core datapath, 16-bit status word
// Notes:   the reset-output pulse length is a plain default, not a measured figure
package pmao_pkg;
  localparam int          PMAO_DW         = 32;
  localparam logic [15:0] SW_RESET_VAL    = 16'h2700;
  localparam int          SW_SUPER_BIT    = 13;
  localparam logic [31:0] STACK_STEP      = 32'h0000_0004;
  localparam logic [31:0] CTL_RESET_VAL   = 32'h0000_0000;
  localparam logic [2:0]  FC_RESET_VAL    = 3'h0;
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          RST_PULSE_NS    = 2560;
  localparam int          RST_PULSE_CYC   = RST_PULSE_NS / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    OP_MOVE_FROM_SW = 5'h00, OP_MOVE_TO_SW   = 5'h01,
    OP_USP_XFER     = 5'h02, OP_CTL_XFER     = 5'h03,
    OP_ALT_SPACE    = 5'h04, OP_SIGNED_MUL   = 5'h05,
    OP_UNSIGNED_MUL = 5'h06, OP_DEC_NEG      = 5'h07,
    OP_NEG          = 5'h08, OP_NEG_BORROW   = 5'h09,
    OP_OR           = 5'h0A, OP_OR_IMM       = 5'h0B,
    OP_OR_IMM_SW    = 5'h0C, OP_PUSH_EA      = 5'h0D,
    OP_RESET        = 5'h0E, OP_ROL          = 5'h0F,
    OP_ROR          = 5'h10, OP_QUICK_LOAD   = 5'h11,
    OP_MULTI_REG    = 5'h12
  } pmao_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2
  } pmao_size_t;

  typedef enum logic [1:0] {
    CTL_SRC_FC = 2'h0, CTL_DST_FC = 2'h1, CTL_USP = 2'h2, CTL_VEC_BASE = 2'h3
  } pmao_ctl_t;

  typedef struct packed {
    pmao_op_t    op;
    pmao_size_t  size;
    logic        wide;      // multiply: 64-bit result into register pair
    logic        toMem;     // direction: register -> memory / control
    logic [31:0] srcVal;
    logic [31:0] dstVal;
    logic [31:0] immData;
    logic [5:0]  count;
    pmao_ctl_t   ctlSel;
    logic [31:0] ea;
    logic [31:0] stackPtr;
    logic [15:0] regList;
    logic        xFlag;
  } pmao_req_t;

  typedef struct packed {
    logic        wbValid;
    logic [3:0]  wbIdx;     // register index, used by multi-register loads
    logic [31:0] wbData;
    logic        wbHiValid;
    logic [31:0] wbHi;
    logic        spValid;
    logic [31:0] spData;
  } pmao_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [2:0]  fc;
  } pmao_mem_t;
endpackage

// ---- core/pmao_exec_unit.sv ----
// Purpose: execute unit for privileged alt_space_transfer, multiply, negate, or, rotate,
//          push address, quick load, multi-register transfer, reset output
// Assumes: register file read is combinational; memory answers with memAck
// Notes:   one request at a time; done pulses once per accepted request
// How it works
// - copy of status word allowed only in supervisor state, else trap.
// - status word load only in supervisor; user state traps, no change.
// - user stack pointer transfers either way need supervisor, else trap.
// - control register transfers either way need supervisor, else trap.
// - alt-space write uses dest code, read uses source code; user traps.
// - multiply forms 16x16 to 32, 32x32 low 32, 32x32 to 64 pair.
// - decimal negate yields zero minus packed decimal operand minus extend.
// - negate yields zero minus operand, two's complement.
// - negate with borrow yields zero minus operand minus extend flag.
// - or combines source and destination bitwise into the destination.
// - or-immediate merges immediate data bitwise into the destination.
// - or-immediate to status word needs supervisor, else trap.
// - push address lowers stack pointer by four, stores address there.
// - reset instruction drives external reset in supervisor, else trap.
// - rotates by register or immediate count, register operand only.
// - quick load writes instruction immediate into a data register.
// - multi-register transfer stores or loads the listed registers.
`timescale 1ns/1ps
module pmao_exec_unit
  import pmao_pkg::*;
#(
  parameter int RST_CYCLES = RST_PULSE_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire pmao_req_t   req,
  output pmao_rsp_t        rsp,
  output logic             done,
  output logic             privTrap,
  output logic [15:0]      statusWord,
  output logic [3:0]       regRdIdx,
  input  wire logic [31:0] regRdData,
  output pmao_mem_t        mem,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata,
  output logic             extResetOut
);
  if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin : g_chk
    $error("RST_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MEM    = 2'b01,
    ST_MULTI  = 2'b10,
    ST_RSTOUT = 2'b11
  } pmao_state_t;

  pmao_state_t state_q;
  logic [15:0] status_q;
  logic [31:0] usp_q;
  logic [31:0] vecBase_q;
  logic [2:0]  srcFc_q;
  logic [2:0]  dstFc_q;
  logic [15:0] list_q;
  logic [31:0] addr_q;
  logic        multiLoad_q;
  logic        inMulti_q;
  logic [3:0]  curIdx_q;
  logic [15:0] rstCnt_q;
  logic        memRead_q;

  logic        start;
  logic        superMode;
  logic        privOp;
  logic        trapNow;
  logic        needsMem;
  logic [31:0] res_d;
  logic [31:0] resHi_d;
  logic        resHiV_d;
  logic [63:0] signed_multiply;
  logic [63:0] unsigned_multiply;
  logic [31:0] mulRes;
  logic [31:0] mulHi;
  logic [7:0]  bcd;
  logic [31:0] ctlRd;

  assign reqReady   = (state_q == ST_IDLE) && !srst;
  assign start      = reqValid && reqReady;
  assign superMode  = status_q[SW_SUPER_BIT];
  assign statusWord = status_q;

  // lowest listed register first; index order fixes the memory order
  function automatic logic [3:0] lowIdx(input logic [15:0] l);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (l[i]) begin
        r = i[3:0];
      end
    end
    return r;
  endfunction

  // replicate narrow operands so a 32-bit rotate yields the narrow rotate
  function automatic logic [31:0] rot(input logic [31:0] v,
                                      input logic [5:0] c,
                                      input pmao_size_t sz,
                                      input logic left);
    logic [31:0] x;
    logic [4:0]  n;
    logic [63:0] w;
    x = v;
    n = c[4:0];
    if (sz == SZ_BYTE) begin
      x = {4{v[7:0]}};
      n = {2'b00, c[2:0]};
    end else if (sz == SZ_WORD) begin
      x = {2{v[15:0]}};
      n = {1'b0, c[3:0]};
    end
    if (!left) begin
      n = 5'(6'd32 - {1'b0, n});
    end
    w = {x, x} << n;
    return w[63:32];
  endfunction

  // keep untouched upper bits of the destination for narrow sizes
  function automatic logic [31:0] merge(input logic [31:0] d,
                                        input logic [31:0] r,
                                        input pmao_size_t sz);
    logic [31:0] m;
    m = r;
    if (sz == SZ_BYTE) begin
      m = {d[31:8], r[7:0]};
    end else if (sz == SZ_WORD) begin
      m = {d[31:16], r[15:0]};
    end
    return m;
  endfunction

  function automatic logic [7:0] decNeg(input logic [7:0] d, input logic x);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = 5'h00 - {1'b0, d[3:0]} - {4'h0, x};
    if (lo[4]) begin
      lo = {1'b1, lo[3:0] - 4'h6};
    end
    hi = 5'h00 - {1'b0, d[7:4]} - {4'h0, lo[4]};
    if (hi[4]) begin
      hi = {1'b1, hi[3:0] - 4'h6};
    end
    return {hi[3:0], lo[3:0]};
  endfunction

  always_comb begin
    unique case (req.op)
      OP_MOVE_FROM_SW, OP_MOVE_TO_SW, OP_USP_XFER, OP_CTL_XFER,
      OP_ALT_SPACE, OP_OR_IMM_SW, OP_RESET: privOp = 1'b1;
      default:                              privOp = 1'b0;
    endcase
  end

  assign trapNow  = start && privOp && !superMode;
  assign needsMem = (req.op == OP_ALT_SPACE) || (req.op == OP_PUSH_EA)
                    || (req.op == OP_MULTI_REG);

  assign signed_multiply = (req.size == SZ_WORD)
                ? 64'($signed(req.srcVal[15:0]) * $signed(req.dstVal[15:0]))
                : 64'($signed(req.srcVal) * $signed(req.dstVal));
  assign unsigned_multiply = (req.size == SZ_WORD)
                ? 64'(req.srcVal[15:0] * req.dstVal[15:0])
                : 64'(req.srcVal) * 64'(req.dstVal);
  assign mulRes = (req.op == OP_SIGNED_MUL) ? signed_multiply[31:0] : unsigned_multiply[31:0];
  assign mulHi  = (req.op == OP_SIGNED_MUL) ? signed_multiply[63:32] : unsigned_multiply[63:32];
  assign bcd    = decNeg(req.dstVal[7:0], req.xFlag);

  always_comb begin
    unique case (req.ctlSel)
      CTL_SRC_FC:   ctlRd = {29'h0000_0000, srcFc_q};
      CTL_DST_FC:   ctlRd = {29'h0000_0000, dstFc_q};
      CTL_USP:      ctlRd = usp_q;
      CTL_VEC_BASE: ctlRd = vecBase_q;
    endcase
  end

  always_comb begin
    res_d    = req.dstVal;
    resHi_d  = 32'h0000_0000;
    resHiV_d = 1'b0;
    unique case (req.op)
      OP_MOVE_FROM_SW: res_d = merge(req.dstVal, {16'h0000, status_q},
                                     SZ_WORD);
      OP_USP_XFER:     res_d = usp_q;
      OP_CTL_XFER:     res_d = ctlRd;
      OP_SIGNED_MUL, OP_UNSIGNED_MUL: begin
        res_d    = mulRes;
        resHi_d  = mulHi;
        resHiV_d = req.wide && (req.size == SZ_LONG);
      end
      OP_DEC_NEG:    res_d = {req.dstVal[31:8], bcd};
      OP_NEG:        res_d = merge(req.dstVal, 32'h0000_0000 - req.dstVal,
                                   req.size);
      OP_NEG_BORROW: res_d = merge(req.dstVal, 32'h0000_0000 - req.dstVal
                                   - {31'h0000_0000, req.xFlag},
                                   req.size);
      OP_OR:         res_d = merge(req.dstVal, req.srcVal | req.dstVal,
                                   req.size);
      OP_OR_IMM:     res_d = merge(req.dstVal, req.immData | req.dstVal,
                                   req.size);
      OP_ROL, OP_ROR: res_d = merge(req.dstVal,
                                    rot(req.dstVal, req.count, req.size,
                                        req.op == OP_ROL),
                                    req.size);
      OP_QUICK_LOAD: res_d = req.immData;
      default:       res_d = req.dstVal;
    endcase
  end

  // privileged state; user-state attempts never reach these writes
  always_ff @(posedge clk) begin
    if (srst) begin
      status_q  <= SW_RESET_VAL;
      usp_q     <= CTL_RESET_VAL;
      vecBase_q <= CTL_RESET_VAL;
      srcFc_q   <= FC_RESET_VAL;
      dstFc_q   <= FC_RESET_VAL;
    end else if (start && superMode) begin
      if (req.op == OP_MOVE_TO_SW) begin
        status_q <= req.srcVal[15:0];
      end
      if (req.op == OP_OR_IMM_SW) begin
        status_q <= status_q | req.immData[15:0];
      end
      if (req.op == OP_USP_XFER && req.toMem) begin
        usp_q <= req.srcVal;
      end
      if (req.op == OP_CTL_XFER && req.toMem) begin
        unique case (req.ctlSel)
          CTL_SRC_FC:   srcFc_q   <= req.srcVal[2:0];
          CTL_DST_FC:   dstFc_q   <= req.srcVal[2:0];
          CTL_USP:      usp_q     <= req.srcVal;
          CTL_VEC_BASE: vecBase_q <= req.srcVal;
        endcase
      end
    end
  end

  assign regRdIdx = lowIdx(list_q);

  // sequencing of memory accesses and the reset pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      mem         <= '0;
      list_q      <= 16'h0000;
      addr_q      <= 32'h0000_0000;
      multiLoad_q <= 1'b0;
      inMulti_q   <= 1'b0;
      curIdx_q    <= 4'h0;
      rstCnt_q    <= 16'h0000;
      memRead_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start && !trapNow && req.op == OP_ALT_SPACE) begin
            mem.valid <= 1'b1;
            mem.write <= req.toMem;
            mem.addr  <= req.ea;
            mem.wdata <= req.srcVal;
            mem.fc    <= req.toMem ? dstFc_q : srcFc_q;
            memRead_q <= !req.toMem;
            inMulti_q <= 1'b0;
            state_q   <= ST_MEM;
          end else if (start && req.op == OP_PUSH_EA) begin
            mem.valid <= 1'b1;
            mem.write <= 1'b1;
            mem.addr  <= req.stackPtr - STACK_STEP;
            mem.wdata <= req.ea;
            mem.fc    <= status_q[SW_SUPER_BIT] ? 3'h5 : 3'h1;
            memRead_q <= 1'b0;
            inMulti_q <= 1'b0;
            state_q   <= ST_MEM;
          end else if (start && req.op == OP_MULTI_REG) begin
            list_q      <= req.regList;
            addr_q      <= req.ea;
            multiLoad_q <= !req.toMem;
            inMulti_q   <= 1'b1;
            state_q     <= ST_MULTI;
          end else if (start && !trapNow && req.op == OP_RESET) begin
            rstCnt_q <= 16'(RST_CYCLES);
            state_q  <= ST_RSTOUT;
          end
        end
        ST_MULTI: begin
          if (list_q == 16'h0000) begin
            inMulti_q <= 1'b0;
            state_q   <= ST_IDLE;
          end else begin
            mem.valid <= 1'b1;
            mem.write <= !multiLoad_q;
            mem.addr  <= addr_q;
            mem.wdata <= regRdData;
            mem.fc    <= status_q[SW_SUPER_BIT] ? 3'h5 : 3'h1;
            memRead_q <= multiLoad_q;
            curIdx_q  <= regRdIdx;
            state_q   <= ST_MEM;
          end
        end
        ST_MEM: begin
          if (memAck) begin
            mem.valid <= 1'b0;
            if (inMulti_q) begin
              list_q[curIdx_q] <= 1'b0;
              addr_q           <= addr_q + STACK_STEP;
              state_q          <= ST_MULTI;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_RSTOUT: begin
          rstCnt_q <= rstCnt_q - 16'h0001;
          if (rstCnt_q == 16'h0001) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign extResetOut = (state_q == ST_RSTOUT);

  // write-back, done and trap pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp      <= '0;
      done     <= 1'b0;
      privTrap <= 1'b0;
    end else begin
      rsp      <= '0;
      done     <= 1'b0;
      privTrap <= trapNow;
      if (trapNow) begin
        done <= 1'b1;
      end else if (start && !needsMem && req.op != OP_RESET) begin
        done          <= 1'b1;
        rsp.wbValid   <= (req.op != OP_MOVE_TO_SW) && (req.op != OP_OR_IMM_SW)
                         && !(req.op inside {OP_USP_XFER, OP_CTL_XFER}
                              && req.toMem);
        rsp.wbData    <= res_d;
        rsp.wbHiValid <= resHiV_d;
        rsp.wbHi      <= resHi_d;
      end else if (start && req.op == OP_PUSH_EA) begin
        rsp.spValid <= 1'b1;
        rsp.spData  <= req.stackPtr - STACK_STEP;
      end else if (state_q == ST_MEM && memAck) begin
        rsp.wbValid <= memRead_q;
        rsp.wbIdx   <= curIdx_q;
        rsp.wbData  <= memRdata;
        done        <= !inMulti_q;
      end else if ((state_q == ST_MULTI && list_q == 16'h0000)
                   || (state_q == ST_RSTOUT && rstCnt_q == 16'h0001)) begin
        done <= 1'b1;
      end
    end
  end

  a_from_sw_trap: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_MOVE_FROM_SW && !superMode
    |=> privTrap && !rsp.wbValid)
    else $error("user status copy did not trap");

  a_to_sw_hold: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_MOVE_TO_SW && !superMode
    |=> privTrap && $stable(status_q))
    else $error("user status load changed status word");

  a_usp_priv: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_USP_XFER && superMode |=> !privTrap && done)
    else $error("supervisor stack pointer transfer misbehaved");

  a_ctl_trap: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_CTL_XFER && !superMode |=> privTrap && !rsp.wbValid)
    else $error("user control transfer did not trap");

  a_alt_fcode: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_ALT_SPACE && superMode && req.toMem
    |=> mem.valid && mem.write && mem.fc == dstFc_q)
    else $error("alternate write used wrong function code");

  a_mul_wide: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_UNSIGNED_MUL && req.wide && req.size == SZ_LONG
    |=> rsp.wbHiValid
        && {rsp.wbHi, rsp.wbData} == $past(req.srcVal) * $past(req.dstVal))
    else $error("64-bit product wrong");

  a_neg_value: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_NEG && req.size == SZ_LONG
    |=> rsp.wbValid && rsp.wbData + $past(req.dstVal) == 32'h0000_0000)
    else $error("negate result wrong");

  a_push_stack: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_PUSH_EA
    |=> mem.valid && mem.write && mem.wdata == $past(req.ea)
        && mem.addr + STACK_STEP == $past(req.stackPtr))
    else $error("push address wrong");

  a_reset_pulse: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_RESET && superMode |=> extResetOut [*8])
    else $error("reset output not held");

  a_quick_load: assert property (@(posedge clk) disable iff (srst)
    start && req.op == OP_QUICK_LOAD
    |=> rsp.wbValid && rsp.wbData == $past(req.immData))
    else $error("quick load wrong");
endmodule

// ---- sim/tb_privileged_move_arith_ops.sv ----
// Purpose: self-checking bench for the privileged/arith execute unit
// Assumes: bench drives inputs at the falling edge; register file modelled
//          combinationally from regRdIdx
// Notes:   short external reset pulse keeps the run brief
`timescale 1ns/1ps
module tb_privileged_move_arith_ops
  import pmao_pkg::*;
;
  localparam int RC = 8;
  logic        clk;
  logic        srst;
  logic        reqValid;
  logic        reqReady;
  pmao_req_t   req;
  pmao_rsp_t   rsp;
  logic        done;
  logic        privTrap;
  logic [15:0] statusWord;
  logic [3:0]  regRdIdx;
  logic [31:0] regRdData;
  pmao_mem_t   mem;
  logic        memAck;
  logic [31:0] memRdata;
  logic        extResetOut;
  int          n_errors;
  int          n_tests;

  pmao_exec_unit #(.RST_CYCLES(RC)) uut (
    .clk(clk), .srst(srst), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rsp(rsp), .done(done), .privTrap(privTrap),
    .statusWord(statusWord), .regRdIdx(regRdIdx), .regRdData(regRdData),
    .mem(mem), .memAck(memAck), .memRdata(memRdata),
    .extResetOut(extResetOut)
  );

  // register i reads back a recognisable tag
  assign regRdData = {28'hA00_0000, regRdIdx};

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    $display("tests %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string msg);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  function automatic pmao_req_t mk(input pmao_op_t op, input logic [31:0] s,
                                   input logic [31:0] d, input logic [31:0] i);
    pmao_req_t r;
    r = '0;
    r.op = op;
    r.size = SZ_LONG;
    r.srcVal = s;
    r.dstVal = d;
    r.immData = i;
    return r;
  endfunction

  // leaves at the falling edge where the edge+1 answer is visible
  // idle edge first: reqValid never drops and rises in one time step
  task automatic run(input pmao_req_t r);
    int i;
    @(negedge clk);
    for (i = 0; i < 50 && reqReady !== 1'b1; i++) @(negedge clk);
    chk(64'(reqReady), 64'h1, "ready");
    req = r;
    reqValid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    reqValid = 1'b0;
  endtask

  task automatic reg_op(input pmao_req_t r, input logic [31:0] exp,
                        input string msg);
    run(r);
    chk(64'(done), 64'h1, msg);
    chk(64'(rsp.wbValid), 64'h1, msg);
    chk(64'(rsp.wbData), 64'(exp), msg);
  endtask

  // waits for the wanted address so a stale request is never acked twice
  task automatic ack(input logic [31:0] addr, input logic [31:0] rd,
                     output pmao_mem_t seen);
    int i;
    for (i = 0; i < 50 && !(mem.valid === 1'b1 && mem.addr === addr); i++)
      @(negedge clk);
    chk(64'(mem.valid), 64'h1, "memory request at address");
    seen = mem;
    memRdata = rd;
    memAck = 1'b1;
    @(posedge clk);
    @(negedge clk);
    memAck = 1'b0;
  endtask

  task automatic wait_done();
    int i;
    for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk);
    chk(64'(done), 64'h1, "completion");
  endtask

  task automatic test_arith();
    pmao_req_t r;
    reg_op(mk(OP_QUICK_LOAD, 0, 0, 32'hFFFF_FF80), 32'hFFFF_FF80, "qload");
    reg_op(mk(OP_NEG, 0, 32'h0000_0001, 0), 32'hFFFF_FFFF, "neg");
    r = mk(OP_NEG, 0, 32'h1234_5601, 0);
    r.size = SZ_BYTE;
    reg_op(r, 32'h1234_56FF, "neg byte");
    r = mk(OP_NEG_BORROW, 0, 32'h0000_0000, 0);
    r.xFlag = 1'b1;
    reg_op(r, 32'hFFFF_FFFF, "negate_with_borrow");
    r = mk(OP_DEC_NEG, 0, 32'h1234_5625, 0);
    r.size = SZ_BYTE;
    r.xFlag = 1'b1;
    reg_op(r, 32'h1234_5674, "dec neg");
    reg_op(mk(OP_OR, 32'h0F0F_0000, 32'h0000_00F0, 0), 32'h0F0F_00F0, "or");
    reg_op(mk(OP_OR_IMM, 0, 32'h0000_0100, 32'h8000_0001), 32'h8000_0101, "ori");
    r = mk(OP_ROL, 0, 32'h1234_5678, 0);
    r.count = 6'd4;
    reg_op(r, 32'h2345_6781, "rol");
    r = mk(OP_ROR, 0, 32'hAAAA_1234, 0);
    r.count = 6'd4;
    r.size = SZ_WORD;
    reg_op(r, 32'hAAAA_4123, "ror word");
    // back to back: second request taken at the edge after the first, while the first answer is visible
    @(negedge clk);
    req = mk(OP_QUICK_LOAD, 0, 0, 32'h0000_0011);
    reqValid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(64'(rsp.wbData), 64'h11, "first of pair");
    req = mk(OP_QUICK_LOAD, 0, 0, 32'h0000_0022);
    @(posedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    chk(64'({done, rsp.wbData}), 64'h1_0000_0022, "second of pair");
    $display("test arith done");
  endtask

  task automatic test_mul();
    pmao_req_t r;
    r = mk(OP_UNSIGNED_MUL, 32'h0000_FFFF, 32'h0000_FFFF, 0);
    r.size = SZ_WORD;
    reg_op(r, 32'hFFFE_0001, "unsigned_multiply word");
    reg_op(mk(OP_SIGNED_MUL, 32'h0001_0000, 32'h0001_0003, 0), 32'h0003_0000, "signed_multiply long");
    r = mk(OP_SIGNED_MUL, 32'hFFFF_FFFE, 32'h0000_0003, 0);
    r.wide = 1'b1;
    reg_op(r, 32'hFFFF_FFFA, "signed_multiply wide low");
    chk(64'({rsp.wbHiValid, rsp.wbHi}), 64'h1_FFFF_FFFF, "signed_multiply wide high");
    r.op = OP_UNSIGNED_MUL;
    reg_op(r, 32'hFFFF_FFFA, "unsigned_multiply wide low");
    chk(64'({rsp.wbHiValid, rsp.wbHi}), 64'h1_0000_0002, "unsigned_multiply wide hi");
    r = mk(OP_SIGNED_MUL, 32'h0000_FFFE, 32'h0000_0003, 0);
    r.size = SZ_WORD;
    reg_op(r, 32'hFFFF_FFFA, "signed_multiply word");
    $display("test multiply done");
  endtask

  task automatic test_super();
    pmao_req_t r;
    pmao_mem_t s;
    r = mk(OP_USP_XFER, 32'h0000_7FF0, 0, 0);
    r.toMem = 1'b1;
    run(r);
    chk(64'({done, privTrap}), 64'h2, "usp write");
    reg_op(mk(OP_USP_XFER, 0, 0, 0), 32'h0000_7FF0, "usp read");
    r = mk(OP_CTL_XFER, 32'h0000_0005, 0, 0);
    r.toMem = 1'b1;
    r.ctlSel = CTL_DST_FC;
    run(r);
    chk(64'({done, privTrap}), 64'h2, "ctl write");
    r.ctlSel = CTL_SRC_FC;
    r.srcVal = 32'h0000_0003;
    run(r);
    r = mk(OP_CTL_XFER, 0, 0, 0);
    r.ctlSel = CTL_DST_FC;
    run(r);
    chk(64'(rsp.wbData[2:0]), 64'h5, "ctl read");
    r.ctlSel = CTL_VEC_BASE;
    r.toMem = 1'b1;
    r.srcVal = 32'h0000_8000;
    run(r);
    r.toMem = 1'b0;
    run(r);
    chk(64'(rsp.wbData), 64'h8000, "vector base");
    r = mk(OP_ALT_SPACE, 32'h1357_9BDF, 0, 0);
    r.toMem = 1'b1;
    r.ea = 32'h0000_2000;
    run(r);
    ack(32'h0000_2000, 0, s);
    chk(64'({s.write, s.fc}), 64'hD, "alt write code");
    wait_done();
    r.toMem = 1'b0;
    r.ea = 32'h0000_2004;
    run(r);
    ack(32'h0000_2004, 32'hCAFE_F00D, s);
    chk(64'({s.write, s.fc}), 64'h3, "alt read code");
    chk(64'(rsp.wbData), 64'hCAFE_F00D, "alt read data");
    run(mk(OP_OR_IMM_SW, 0, 0, 32'h0000_0010));
    chk(64'(statusWord), 64'h2710, "ori status");
    reg_op(mk(OP_MOVE_FROM_SW, 0, 0, 0), 32'h0000_2710, "copy status");
    $display("test supervisor done");
  endtask

  task automatic test_mem();
    pmao_req_t r;
    pmao_mem_t s;
    r = mk(OP_PUSH_EA, 0, 0, 0);
    r.stackPtr = 32'h0000_1000;
    r.ea = 32'h0000_BEEF;
    run(r);
    chk(64'({rsp.spValid, rsp.spData}), 64'h1_0000_0FFC, "push sp");
    ack(32'h0000_0FFC, 0, s);
    chk(64'({s.write, s.wdata}), 64'h1_0000_BEEF, "push store");
    wait_done();
    r = mk(OP_MULTI_REG, 0, 0, 0);
    r.toMem = 1'b1;
    r.regList = 16'h0003;
    r.ea = 32'h0000_3000;
    run(r);
    ack(32'h0000_3000, 0, s);
    chk(64'({s.write, s.wdata}), 64'h1_A000_0000, "multi first");
    ack(32'h0000_3004, 0, s);
    chk(64'({s.write, s.wdata}), 64'h1_A000_0001, "multi second");
    wait_done();
    r.toMem = 1'b0;
    r.regList = 16'h0004;
    r.ea = 32'h0000_3100;
    run(r);
    ack(32'h0000_3100, 32'h5555_AAAA, s);
    chk(64'({s.write, rsp.wbValid, rsp.wbIdx, rsp.wbData}),
        64'h0000_0012_5555_AAAA, "multi load");
    wait_done();
    run(mk(OP_RESET, 0, 0, 0));
    begin
      int i;
      int cnt;
      cnt = 0;
      for (i = 0; i < 60 && done !== 1'b1; i++) begin
        if (extResetOut === 1'b1) cnt++;
        @(negedge clk);
      end
      chk(64'(cnt), 64'(RC), "reset pulse length");
    end
    $display("test memory done");
  endtask

  task automatic test_user();
    pmao_op_t  ops [7];
    pmao_req_t r;
    int        k;
    ops = '{OP_MOVE_FROM_SW, OP_MOVE_TO_SW, OP_USP_XFER, OP_CTL_XFER,
            OP_ALT_SPACE, OP_OR_IMM_SW, OP_RESET};
    run(mk(OP_MOVE_TO_SW, 32'h0000_0000, 0, 0));
    chk(64'({privTrap, statusWord}), 64'h0, "enter user");
    for (k = 0; k < 7; k++) begin
      r = mk(ops[k], 32'h0000_2700, 0, 32'h0000_2000);
      r.toMem = 1'b1;
      run(r);
      chk(64'({privTrap, done, rsp.wbValid, mem.valid}), 64'hC, "trap");
      chk(64'({extResetOut, statusWord}), 64'h0, "state kept");
    end
    reg_op(mk(OP_QUICK_LOAD, 0, 0, 32'h0000_0042), 32'h0000_0042, "user qload");
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    chk(64'(statusWord), 64'h2700, "status after reset");
    run(mk(OP_USP_XFER, 0, 0, 0));
    chk(64'({privTrap, done}), 64'h1, "supervisor again");
    $display("test user traps done");
  endtask

  initial begin
    n_errors = 0;
    n_tests = 0;
    srst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    memAck = 1'b0;
    memRdata = '0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk(64'({reqReady, statusWord}), 64'h2700, "in reset");
    srst = 1'b0;
    @(negedge clk);
    test_arith();
    test_mul();
    test_super();
    test_mem();
    test_user();
    final_report();
  end

  // tests need well under a thousand cycles
  initial begin
    #(20000 * 5);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
